// file: include/rsvc_pkg.sv
// constants and carrier types for the reassembly service register block
`default_nettype none

package rsvc_pkg;

    // register indices as printed, byte address is four times the index
    localparam logic [31:0] RSVC_IDX_ENABLE = 32'h0000_2042;
    localparam logic [31:0] RSVC_IDX_STATUS = 32'h0000_2044;
    localparam logic [31:0] RSVC_IDX_CWRAP = 32'h0000_2046;
    localparam logic [31:0] RSVC_IDX_COUNT = 32'h0000_2048;
    localparam logic [31:0] RSVC_ADDR_ENABLE = {RSVC_IDX_ENABLE[29:0], 2'b00};
    localparam logic [31:0] RSVC_ADDR_STATUS = {RSVC_IDX_STATUS[29:0], 2'b00};
    localparam logic [31:0] RSVC_ADDR_CWRAP = {RSVC_IDX_CWRAP[29:0], 2'b00};
    localparam logic [31:0] RSVC_ADDR_COUNT = {RSVC_IDX_COUNT[29:0], 2'b00};

    // field layout
    localparam int RSVC_KINDS = 11;
    localparam int RSVC_BASE_W = 14;
    localparam int RSVC_FWD_BIT = 14;
    localparam int RSVC_FLAG_BIT = 15;
    localparam int RSVC_CFWD_BIT = 0;
    localparam int RSVC_CFLAG_BIT = 1;
    localparam int RSVC_CNT_W = 16;

    // reset values
    localparam logic [RSVC_KINDS-1:0] RSVC_ENABLE_RST = 11'h000;
    localparam logic [RSVC_BASE_W-1:0] RSVC_BASE_RST = 14'h0000;
    localparam logic [RSVC_CNT_W-1:0] RSVC_COUNT_RST = 16'h0000;
    localparam logic [31:0] RSVC_RDATA_RST = 32'h0000_0000;

    // ahb encodings
    localparam logic [1:0] RSVC_HTRANS_NONSEQ = 2'h2;
    localparam logic RSVC_HRESP_OKAY = 1'h0;

    // one report from a control structure, valid for one cycle
    typedef struct packed {
        logic valid;
        logic [RSVC_KINDS-1:0] kinds;
        logic [RSVC_BASE_W-1:0] base;
    } rsvc_event_t;

    typedef enum logic {RSVC_IDLE, RSVC_BUSY} rsvc_bus_state_t;

endpackage : rsvc_pkg

`default_nettype wire

// file: hw/rsvc_flag.sv
// sticky status flag where a set beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module rsvc_flag (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic set,
    input wire logic clr,
    // state
    output logic q
);

    logic flag_d;
    logic flag_q;

    always_comb begin
        flag_d = flag_q;
        if (ce) begin
            if (set) begin
                flag_d = 1'b1;
            end else if (clr) begin
                flag_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;

endmodule : rsvc_flag

`default_nettype wire

// file: hw/rsvc_regs.sv
// reassembly service event registers behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

module rsvc_regs
    import rsvc_pkg::*;
(
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // reassembly engine
    input wire rsvc_event_t ev,
    input wire logic cell_rx,
    // towards main status
    output logic main_reassembly_service_bit
);

    // bus front end
    rsvc_bus_state_t state_q;
    rsvc_bus_state_t state_d;
    logic [31:0] addr_q;
    logic [31:0] addr_d;
    logic wr_q;
    logic wr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic hreadyout_q;
    logic hreadyout_d;
    logic take;
    logic wr_stb;
    logic rd_stb;

    // one wait state on every NONSEQ transfer so read data leave a flop
    assign take = hsel && hready && (htrans == RSVC_HTRANS_NONSEQ);
    assign wr_stb = ce && (state_q == RSVC_BUSY) && wr_q;
    assign rd_stb = ce && (state_q == RSVC_BUSY) && !wr_q;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wr_d = wr_q;
        hreadyout_d = hreadyout_q;
        if (ce) begin
            unique case (state_q)
                RSVC_IDLE: begin
                    if (take) begin
                        state_d = RSVC_BUSY;
                        addr_d = haddr;
                        wr_d = hwrite;
                        hreadyout_d = 1'b0;
                    end
                end
                RSVC_BUSY: begin
                    state_d = RSVC_IDLE;
                    hreadyout_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= RSVC_IDLE;
            addr_q <= 32'h0000_0000;
            wr_q <= 1'b0;
            hreadyout_q <= 1'b1;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            hreadyout_q <= hreadyout_d;
        end
    end

    // register file
    logic [RSVC_KINDS-1:0] en_q;
    logic [RSVC_KINDS-1:0] en_d;
    logic sfwd_q;
    logic sfwd_d;
    logic cfwd_q;
    logic cfwd_d;
    logic [RSVC_BASE_W-1:0] base_q;
    logic [RSVC_BASE_W-1:0] base_d;
    logic [RSVC_CNT_W-1:0] count_q;
    logic [RSVC_CNT_W-1:0] count_d;
    logic main_q;
    logic main_d;
    logic sum_flag;
    logic cnt_flag;
    logic [RSVC_KINDS-1:0] ev_hits;
    logic ev_hit;
    logic sum_clr;
    logic cnt_clr;
    logic cnt_wrap;

    assign ev_hits = ev.kinds & en_q;
    // each kind has its own enable
    assign ev_hit = ev.valid && (|ev_hits);
    assign sum_clr = wr_stb && (addr_q == RSVC_ADDR_STATUS)
        && !hwdata[RSVC_FLAG_BIT];
    assign cnt_clr = wr_stb && (addr_q == RSVC_ADDR_CWRAP)
        && !hwdata[RSVC_CFLAG_BIT];
    assign cnt_wrap = cell_rx && (&count_q);

    // set wins over a software clear in the same cycle
    rsvc_flag u_sum_flag (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .set(ev_hit),
        .clr(sum_clr),
        .q(sum_flag)
    );

    rsvc_flag u_cnt_flag (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .set(cnt_wrap),
        .clr(cnt_clr),
        .q(cnt_flag)
    );

    always_comb begin
        en_d = en_q;
        sfwd_d = sfwd_q;
        cfwd_d = cfwd_q;
        base_d = base_q;
        count_d = count_q;
        main_d = main_q;
        if (ce) begin
            if (wr_stb && (addr_q == RSVC_ADDR_ENABLE)) begin
                en_d = hwdata[RSVC_KINDS-1:0];
            end
            if (wr_stb && (addr_q == RSVC_ADDR_STATUS)) begin
                sfwd_d = hwdata[RSVC_FWD_BIT];
            end
            if (wr_stb && (addr_q == RSVC_ADDR_CWRAP)) begin
                cfwd_d = hwdata[RSVC_CFWD_BIT];
            end
            // a fresh event keeps its address even against a clear
            if (ev_hit) begin
                base_d = ev.base;
            end else if (sum_clr) begin
                base_d = RSVC_BASE_RST;
            end
            // free-running wrap, no saturation
            if (cell_rx) begin
                count_d = count_q + 16'h0001;
            end
            // forwarding uses the flags as they stand, one cycle late
            main_d = (sum_flag && sfwd_q)
                || (cnt_flag && cfwd_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= RSVC_ENABLE_RST;
            sfwd_q <= 1'b0;
            cfwd_q <= 1'b0;
            base_q <= RSVC_BASE_RST;
            count_q <= RSVC_COUNT_RST;
            main_q <= 1'b0;
        end else begin
            en_q <= en_d;
            sfwd_q <= sfwd_d;
            cfwd_q <= cfwd_d;
            base_q <= base_d;
            count_q <= count_d;
            main_q <= main_d;
        end
    end

    // read data, reserved bits and unmapped words read zero
    always_comb begin
        hrdata_d = hrdata_q;
        if (rd_stb) begin
            unique case (addr_q)
                RSVC_ADDR_ENABLE: hrdata_d = {21'h000000, en_q};
                RSVC_ADDR_STATUS: hrdata_d = {16'h0000, sum_flag, sfwd_q, base_q};
                RSVC_ADDR_CWRAP: hrdata_d = {30'h00000000, cnt_flag, cfwd_q};
                RSVC_ADDR_COUNT: hrdata_d = {16'h0000, count_q};
                default: hrdata_d = RSVC_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= RSVC_RDATA_RST;
        end else begin
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign main_reassembly_service_bit = main_q;

    // hresp is a flop held at okay, every access completes
    logic hresp_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_q <= RSVC_HRESP_OKAY;
        end else begin
            hresp_q <= RSVC_HRESP_OKAY;
        end
    end

    assign hresp = hresp_q;

    // checks
    sequence s_addr_phase;
        ce && take && (state_q == RSVC_IDLE);
    endsequence

    sequence s_wait_then_ready;
        !hreadyout ##1 (hreadyout || !ce);
    endsequence

    property p_bus_answer;
        @(posedge hclk) disable iff (!hresetn)
        s_addr_phase |=> s_wait_then_ready;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("transfer not answered after one wait state");

    generate
        for (genvar gi = 0; gi < RSVC_KINDS; gi++) begin : g_kind
            property p_kind_sets;
                @(posedge hclk) disable iff (!hresetn)
                (ce && ev.valid && ev.kinds[gi] && en_q[gi]) |=> sum_flag;
            endproperty
            a_kind_sets: assert property (p_kind_sets)
                else $error("enabled event kind did not set summary flag");
        end
    endgenerate

    property p_base_capture;
        @(posedge hclk) disable iff (!hresetn)
        (ce && ev_hit) |=> (base_q == $past(ev.base)) && sum_flag;
    endproperty
    a_base_capture: assert property (p_base_capture)
        else $error("event base address not captured");

    property p_base_clear;
        @(posedge hclk) disable iff (!hresetn)
        (ce && sum_clr && !ev_hit) |=> (base_q == RSVC_BASE_RST) && !sum_flag;
    endproperty
    a_base_clear: assert property (p_base_clear)
        else $error("flag clear left base address or flag set");

    property p_sum_forward;
        @(posedge hclk) disable iff (!hresetn)
        (ce && sum_flag && sfwd_q) |=> main_reassembly_service_bit;
    endproperty
    a_sum_forward: assert property (p_sum_forward)
        else $error("summary flag not forwarded");

    property p_sum_masked;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !sum_flag && !ev_hit) |=> !sum_flag;
    endproperty
    a_sum_masked: assert property (p_sum_masked)
        else $error("summary flag set without unmasked event");

    property p_sum_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (sum_flag && !sum_clr) |=> sum_flag;
    endproperty
    a_sum_sticky: assert property (p_sum_sticky)
        else $error("summary flag dropped without a clearing write");

    property p_cnt_forward;
        @(posedge hclk) disable iff (!hresetn)
        (ce && cnt_flag && cfwd_q) |=> main_reassembly_service_bit;
    endproperty
    a_cnt_forward: assert property (p_cnt_forward)
        else $error("count wrap flag not forwarded");

    property p_no_forward;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !(sum_flag && sfwd_q) && !(cnt_flag && cfwd_q))
            |=> !main_reassembly_service_bit;
    endproperty
    a_no_forward: assert property (p_no_forward)
        else $error("service bit set with nothing forwarded");

    property p_wrap_latch;
        @(posedge hclk) disable iff (!hresetn)
        (ce && cell_rx && (count_q == 16'hFFFF))
            |=> cnt_flag && (count_q == RSVC_COUNT_RST);
    endproperty
    a_wrap_latch: assert property (p_wrap_latch)
        else $error("counter wrap did not latch flag or reach zero");

    property p_cnt_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (cnt_flag && !cnt_clr) |=> cnt_flag;
    endproperty
    a_cnt_sticky: assert property (p_cnt_sticky)
        else $error("count wrap flag dropped without a clearing write");

    property p_count_step;
        @(posedge hclk) disable iff (!hresetn)
        (ce && cell_rx) |=> (count_q == $past(count_q) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("received cell not counted");

    property p_count_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!cell_rx || !ce) |=> $stable(count_q);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("counter moved without a cell");

endmodule : rsvc_regs

`default_nettype wire

// file: bench/tb_reassembly_event_service_regs.sv
// self-checking bench for the reassembly service register block
`timescale 1ns/1ps
`default_nettype none

module tb_reassembly_event_service_regs;
    import rsvc_pkg::*;

    logic hclk;
    logic hresetn;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    wire logic hready;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    rsvc_event_t ev;
    logic cell_rx;
    logic main_reassembly_service_bit;
    int miscompares;
    int n_checks;
    int cycles = 0;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    rsvc_regs rsvc_regs_inst (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ev(ev), .cell_rx(cell_rx),
        .main_reassembly_service_bit(main_reassembly_service_bit)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // the counter wrap alone takes 65536 cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t main got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    // one single-word transfer, waiting on ready in both phases
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= RSVC_HTRANS_NONSEQ;
        haddr <= addr;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, addr, wd, rd);
    endtask : wr

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, addr, 32'h0000_0000, rd);
        chk_reg(rd, exp);
    endtask : rd_chk

    task automatic send_ev(input logic [RSVC_KINDS-1:0] kinds, input logic [13:0] base);
        @(posedge hclk);
        ev <= {1'b1, kinds, base};
        @(posedge hclk);
        ev.valid <= 1'b0;
    endtask : send_ev

    task automatic cells(input int n);
        @(posedge hclk);
        cell_rx <= 1'b1;
        repeat (n) @(posedge hclk);
        cell_rx <= 1'b0;
    endtask : cells

    task automatic t_reset_map;
        rd_chk(RSVC_ADDR_ENABLE, 32'h0000_0000);
        rd_chk(RSVC_ADDR_STATUS, 32'h0000_0000);
        rd_chk(RSVC_ADDR_CWRAP, 32'h0000_0000);
        rd_chk(RSVC_ADDR_COUNT, 32'h0000_0000);
        wr(RSVC_ADDR_COUNT + 32'h0000_0008, 32'hFFFF_FFFF);
        rd_chk(RSVC_ADDR_COUNT + 32'h0000_0008, 32'h0000_0000);
        wr(RSVC_ADDR_ENABLE, 32'hFFFF_FFFF);
        rd_chk(RSVC_ADDR_ENABLE, 32'h0000_07FF);
        chk_bit(hresp, RSVC_HRESP_OKAY);
    endtask : t_reset_map

    // each kind alone: masked by the others, then latched with its base
    task automatic t_kinds;
        logic [RSVC_KINDS-1:0] one;
        logic [13:0] base;
        for (int i = 0; i < RSVC_KINDS; i++) begin
            one = 11'h001 << i;
            base = 14'h2000 | 14'(i * 37 + 1);
            wr(RSVC_ADDR_ENABLE, {21'h0, one});
            send_ev(~one, 14'h1555);
            rd_chk(RSVC_ADDR_STATUS, 32'h0000_0000);
            send_ev(one, base);
            rd_chk(RSVC_ADDR_STATUS, {16'h0, 2'b10, base});
            wr(RSVC_ADDR_STATUS, 32'h0000_0000);
            rd_chk(RSVC_ADDR_STATUS, 32'h0000_0000);
        end
    endtask : t_kinds

    task automatic t_forward;
        wr(RSVC_ADDR_ENABLE, 32'h0000_0001);
        wr(RSVC_ADDR_STATUS, 32'h0000_4000);
        chk_bit(main_reassembly_service_bit, 1'b0);
        send_ev(11'h001, 14'h3ABC);
        rd_chk(RSVC_ADDR_STATUS, 32'h0000_FABC);
        send_ev(11'h001, 14'h0123);
        rd_chk(RSVC_ADDR_STATUS, 32'h0000_C123);
        chk_bit(main_reassembly_service_bit, 1'b1);
        wr(RSVC_ADDR_STATUS, 32'h0000_C000);
        rd_chk(RSVC_ADDR_STATUS, 32'h0000_C123);
        wr(RSVC_ADDR_STATUS, 32'h0000_4000);
        repeat (2) @(posedge hclk);
        chk_bit(main_reassembly_service_bit, 1'b0);
        rd_chk(RSVC_ADDR_STATUS, 32'h0000_4000);
        wr(RSVC_ADDR_STATUS, 32'h0000_0000);
    endtask : t_forward

    // count up, wrap at all ones, flag sticks until a zero write
    task automatic t_counter;
        cells(3);
        rd_chk(RSVC_ADDR_COUNT, 32'h0000_0003);
        rd_chk(RSVC_ADDR_CWRAP, 32'h0000_0000);
        cells(65532);
        rd_chk(RSVC_ADDR_COUNT, 32'h0000_FFFF);
        rd_chk(RSVC_ADDR_CWRAP, 32'h0000_0000);
        cells(2);
        rd_chk(RSVC_ADDR_COUNT, 32'h0000_0001);
        rd_chk(RSVC_ADDR_CWRAP, 32'h0000_0002);
        chk_bit(main_reassembly_service_bit, 1'b0);
        wr(RSVC_ADDR_CWRAP, 32'h0000_0003);
        repeat (2) @(posedge hclk);
        chk_bit(main_reassembly_service_bit, 1'b1);
        rd_chk(RSVC_ADDR_CWRAP, 32'h0000_0003);
        wr(RSVC_ADDR_CWRAP, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk_bit(main_reassembly_service_bit, 1'b0);
        rd_chk(RSVC_ADDR_CWRAP, 32'h0000_0001);
    endtask : t_counter

    // enable low must freeze counter, flags and base alike
    task automatic t_freeze;
        @(posedge hclk);
        ce <= 1'b0;
        cells(4);
        send_ev(11'h001, 14'h0456);
        @(posedge hclk);
        ce <= 1'b1;
        rd_chk(RSVC_ADDR_COUNT, 32'h0000_0001);
        rd_chk(RSVC_ADDR_STATUS, 32'h0000_0000);
        chk_bit(main_reassembly_service_bit, 1'b0);
    endtask : t_freeze

    initial begin
        miscompares = 0;
        n_checks = 0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        ev = '0;
        cell_rx = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_map();
        t_kinds();
        t_forward();
        t_counter();
        t_freeze();
        end_sim();
    end

endmodule : tb_reassembly_event_service_regs

`default_nettype wire
